// *** tpf_triac_ctrl.sv ***
`timescale 1ns/1ps
module tpf_triac_ctrl #(
    parameter int TICK_CYCLES = tpf_pkg::TICK_CYCLES,
    parameter int WDT_CYCLES  = tpf_pkg::WDT_CYCLES
) (
    // Clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    // Zero-crossing detector level
    input  wire logic                       zero_cross_in,
    // A/D converter on the potentiometer channel
    output logic                            adc_enable,
    output logic                            adc_start,
    input  wire logic                       adc_done,
    input  wire logic [tpf_pkg::ADC_W-1:0]  pot_analog_input,
    // Triac gate drive: gate pins active low, output enable active high
    output logic                            gate_trigger_out_a_n,
    output logic                            gate_trigger_out_b_n,
    output logic                            gate_drive_oe,
    // Status
    output logic [1:0]                      mode,
    output logic                            mains_is_60hz,
    output logic                            wdt_reset
);

    // Divider end counts
    localparam logic [tpf_pkg::TICK_CNT_W-1:0] TICK_LAST =
        tpf_pkg::TICK_CNT_W'(TICK_CYCLES - 1);
    localparam logic [tpf_pkg::WDT_CNT_W-1:0]  WDT_LAST  =
        tpf_pkg::WDT_CNT_W'(WDT_CYCLES - 1);
    localparam logic [tpf_pkg::US_CNT_W-1:0]   US_LAST   =
        tpf_pkg::US_CNT_W'(tpf_pkg::CYC_PER_US - 1);

    // Sequencer states
    tpf_pkg::tpf_mode_t                mode_reg;
    tpf_pkg::tpf_adc_t                 adc_state_reg;

    // Combined reset
    logic                              sys_rst;

    // Crossing detection
    logic                              zc_meta_reg;
    logic                              zc_sync_reg;
    logic                              zc_prev_reg;
    logic                              zc_rise;
    logic                              zc_fall;
    logic                              zc_event;
    logic                              restart_half;

    // Tick timer and burst
    logic                              half_is_pos_reg;
    logic                              tick_run_reg;
    logic [tpf_pkg::TICK_CNT_W-1:0]    tick_div_reg;
    logic                              tick;
    logic [tpf_pkg::TICKS_W-1:0]       tick_count_reg;
    logic [tpf_pkg::TICKS_W-1:0]       fire_at;
    logic                              burst_reg;
    logic [3:0]                        burst_cnt_reg;
    logic                              gate_low;

    // Period measurement
    logic [tpf_pkg::US_CNT_W-1:0]      us_div_reg;
    logic                              us_tick;
    logic                              meas_run_reg;
    logic [tpf_pkg::PERIOD_W-1:0]      period_reg;
    logic [tpf_pkg::SUM_W-1:0]         sum_reg;
    logic [tpf_pkg::SUM_W-1:0]         sum_next;
    logic [2:0]                        interval_cnt_reg;
    logic                              mains_60_reg;

    // Firing delay
    logic [tpf_pkg::DELAY_W-1:0]       delay_reg;
    logic [tpf_pkg::DELAY_W-1:0]       scaled;
    logic [tpf_pkg::DELAY_W-1:0]       delay_cap;

    // Watchdog
    logic [tpf_pkg::WDT_CNT_W-1:0]     wdt_cnt_reg;
    logic                              wdt_fire_reg;

    // Output flip-flops
    logic                              adc_en_reg;
    logic                              adc_start_reg;
    logic                              gate_a_reg;
    logic                              gate_b_reg;
    logic                              gate_oe_reg;

    // Watchdog overflow runs the same initialisation as the system reset
    assign sys_rst = rst | wdt_fire_reg; // RULE_16

    // Two-stage synchroniser; only the second stage feeds edge detection
    // No reset, so reset fakes no edge
    always_ff @(posedge clk_sys) begin
        zc_meta_reg <= zero_cross_in; // RULE_21
        zc_sync_reg <= zc_meta_reg;
        zc_prev_reg <= zc_sync_reg;
    end

    // Rising edge is the positive crossing, falling edge the negative one
    assign zc_rise  = zc_sync_reg & ~zc_prev_reg; // RULE_21
    assign zc_fall  = ~zc_sync_reg & zc_prev_reg; // RULE_21
    // Any crossing services the watchdog
    assign zc_event = zc_rise | zc_fall;

    // Crossings that restart the tick timer in normal operation
    assign restart_half = (mode_reg == tpf_pkg::TPF_POS_HALF && zc_rise) ||
                          (mode_reg == tpf_pkg::TPF_NEG_HALF && zc_fall);

    // Mode sequencer, stepped only by crossing events
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            mode_reg <= tpf_pkg::TPF_SYNC; // RULE_02
        end else begin
            case (mode_reg) // RULE_01
                tpf_pkg::TPF_POS_HALF: begin
                    if (zc_rise) begin
                        mode_reg <= tpf_pkg::TPF_NEG_HALF; // RULE_03
                    end
                end

                tpf_pkg::TPF_NEG_HALF: begin
                    if (zc_fall) begin
                        mode_reg <= tpf_pkg::TPF_POS_HALF; // RULE_04
                    end
                end

                tpf_pkg::TPF_SYNC: begin
                    // Positive edge only, so measurement starts on a cycle boundary
                    if (zc_rise) begin
                        mode_reg <= tpf_pkg::TPF_DETECT; // RULE_05
                    end
                end

                tpf_pkg::TPF_DETECT: begin
                    if (zc_rise && interval_cnt_reg == tpf_pkg::MEAS_INTERVALS - 3'h1) begin
                        mode_reg <= tpf_pkg::TPF_POS_HALF; // RULE_06
                    end
                end

                default: begin
                    // Unused code resynchronises
                    mode_reg <= tpf_pkg::TPF_SYNC;
                end
            endcase
        end
    end

    // Microsecond enable for the period timer
    // Held at zero while idle
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !meas_run_reg) begin
            us_div_reg <= '0;
        end else if (us_div_reg == US_LAST) begin
            us_div_reg <= '0;
        end else begin
            us_div_reg <= us_div_reg + 1'b1;
        end
    end

    assign us_tick  = meas_run_reg && us_div_reg == US_LAST;
    // Running total of intervals
    assign sum_next = sum_reg + tpf_pkg::SUM_W'(period_reg);

    // Period measurement: 16-bit timer, saturating, restarted at each positive edge
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            meas_run_reg     <= 1'b0;
            period_reg       <= '0;
            sum_reg          <= '0;
            interval_cnt_reg <= '0;
            mains_60_reg     <= 1'b0;
        end else if (mode_reg == tpf_pkg::TPF_SYNC && zc_rise) begin
            // Positive edge keeps whole cycles
            meas_run_reg     <= 1'b1; // RULE_05
            period_reg       <= '0;
            sum_reg          <= '0;
            interval_cnt_reg <= '0;
        end else if (mode_reg == tpf_pkg::TPF_DETECT && zc_rise) begin
            period_reg       <= '0;
            sum_reg          <= sum_next;
            interval_cnt_reg <= interval_cnt_reg + 3'h1;
            if (interval_cnt_reg == tpf_pkg::MEAS_INTERVALS - 3'h1) begin
                // Sum against five thresholds avoids a divider for the average
                meas_run_reg <= 1'b0; // RULE_06
                mains_60_reg <= sum_next < tpf_pkg::MAINS_THRESH_SUM; // RULE_06
            end
        end else if (us_tick && period_reg != '1) begin
            // Saturates instead of wrapping
            period_reg <= period_reg + 1'b1;
        end
    end

    // Tick timer: clears and restarts on match, stopped when idle
    // A restart makes the first tick a full period
    always_ff @(posedge clk_sys) begin
        if (sys_rst || restart_half || !tick_run_reg) begin
            tick_div_reg <= '0;
        end else if (tick_div_reg == TICK_LAST) begin
            tick_div_reg <= '0; // RULE_17
        end else begin
            tick_div_reg <= tick_div_reg + 1'b1;
        end
    end

    assign tick = tick_run_reg && !restart_half && tick_div_reg == TICK_LAST; // RULE_17

    // Firing point in ticks since crossing, with mark-space compensation
    assign fire_at = tpf_pkg::TICKS_W'(delay_reg) +
                     (half_is_pos_reg ? tpf_pkg::POS_OFFSET : tpf_pkg::NEG_OFFSET); // RULE_12

    // Tick count and burst; the run flag drops once the burst is spent
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tick_run_reg    <= 1'b0;
            half_is_pos_reg <= 1'b1;
            tick_count_reg  <= '0;
            burst_reg       <= 1'b0;
            burst_cnt_reg   <= '0;
        end else if (restart_half) begin
            // Also abandons a burst in progress
            tick_run_reg    <= 1'b1; // RULE_03 RULE_04
            half_is_pos_reg <= zc_rise;
            tick_count_reg  <= '0;
            burst_reg       <= 1'b0;
            burst_cnt_reg   <= '0;
        end else if (tick) begin
            if (burst_reg) begin
                // Eighth tick ends burst and timer
                if (burst_cnt_reg == tpf_pkg::BURST_TICKS - 4'h1) begin
                    burst_reg    <= 1'b0;
                    tick_run_reg <= 1'b0; // RULE_14
                end else begin
                    burst_cnt_reg <= burst_cnt_reg + 4'h1; // RULE_13
                end
            end else if (tick_count_reg + 1'b1 == fire_at || fire_at == '0) begin
                burst_reg     <= 1'b1; // RULE_11
                burst_cnt_reg <= '0;
            end else begin
                tick_count_reg <= tick_count_reg + 1'b1; // RULE_11
            end
        end
    end

    // Even burst steps drive the gate low, odd steps leave a one-tick gap
    assign gate_low = burst_reg && !burst_cnt_reg[0]; // RULE_13 RULE_17

    // Gate pins: made outputs and held high from reset, low only in a burst
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            gate_oe_reg <= 1'b1; // RULE_15
            gate_a_reg  <= tpf_pkg::GATE_IDLE; // RULE_15 RULE_18
            gate_b_reg  <= tpf_pkg::GATE_IDLE; // RULE_18
        end else begin
            // One burst drives both pins
            gate_oe_reg <= 1'b1;
            gate_a_reg  <= ~gate_low; // RULE_18
            gate_b_reg  <= ~gate_low; // RULE_18
        end
    end

    // Scale and clamp; larger result means later firing and less power
    // Cap keeps firing inside the half cycle
    assign scaled    = pot_analog_input[tpf_pkg::ADC_W-1:tpf_pkg::ADC_SHIFT]; // RULE_20
    assign delay_cap = mains_60_reg ? tpf_pkg::DELAY_MAX_60 : tpf_pkg::DELAY_MAX_50; // RULE_09

    // Conversion sequencer: dummy conversion, then the one that counts
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            adc_state_reg <= tpf_pkg::TPF_ADC_IDLE;
            adc_en_reg    <= 1'b0;
            adc_start_reg <= 1'b0;
            delay_reg     <= tpf_pkg::DELAY_RESET;
        end else begin
            adc_start_reg <= 1'b0;
            case (adc_state_reg)
                tpf_pkg::TPF_ADC_IDLE: begin
                    // Power up and start together
                    if (mode_reg == tpf_pkg::TPF_POS_HALF && zc_rise) begin
                        adc_en_reg    <= 1'b1; // RULE_08
                        adc_start_reg <= 1'b1; // RULE_03
                        adc_state_reg <= tpf_pkg::TPF_ADC_DUMMY;
                    end
                end

                tpf_pkg::TPF_ADC_DUMMY: begin
                    // A late converter must not push the update past the first tick
                    if (tick) begin
                        adc_en_reg    <= 1'b0; // RULE_10
                        adc_state_reg <= tpf_pkg::TPF_ADC_IDLE;
                    end else if (adc_done) begin
                        adc_start_reg <= 1'b1; // RULE_07
                        adc_state_reg <= tpf_pkg::TPF_ADC_REAL;
                    end
                end

                tpf_pkg::TPF_ADC_REAL: begin
                    // Only this result sets the delay
                    if (tick) begin
                        adc_en_reg    <= 1'b0; // RULE_10
                        adc_state_reg <= tpf_pkg::TPF_ADC_IDLE;
                    end else if (adc_done) begin
                        delay_reg     <= (scaled > delay_cap) ? delay_cap : scaled; // RULE_07 RULE_09
                        adc_en_reg    <= 1'b0; // RULE_08
                        adc_state_reg <= tpf_pkg::TPF_ADC_IDLE;
                    end
                end

                default: begin
                    // Unused state powers down
                    adc_en_reg    <= 1'b0;
                    adc_state_reg <= tpf_pkg::TPF_ADC_IDLE;
                end
            endcase
        end
    end

    // Watchdog serviced by every crossing event; silent mains re-initialises
    // Fire pulse clears itself next edge
    always_ff @(posedge clk_sys) begin
        if (rst || wdt_fire_reg || zc_event) begin
            wdt_cnt_reg  <= '0;
            wdt_fire_reg <= 1'b0;
        end else if (wdt_cnt_reg == WDT_LAST) begin
            wdt_cnt_reg  <= '0;
            wdt_fire_reg <= 1'b1; // RULE_19
        end else begin
            wdt_cnt_reg  <= wdt_cnt_reg + 1'b1;
        end
    end

    // All outputs are flip-flops
    assign adc_enable           = adc_en_reg;
    assign adc_start            = adc_start_reg;

    // Gate drive
    assign gate_trigger_out_a_n = gate_a_reg;
    assign gate_trigger_out_b_n = gate_b_reg;
    assign gate_drive_oe        = gate_oe_reg;

    // Status
    assign mode                 = mode_reg;
    assign mains_is_60hz        = mains_60_reg;
    assign wdt_reset            = wdt_fire_reg;

endmodule

// *** tpf_pkg.sv ***
// What this block does
// RULE_01 - Each zero-crossing event acts according to a four-valued mode, 0 to 3.
// RULE_02 - After reset the mode starts at 2, mains synchronisation.
// RULE_03 - Mode 0, positive crossing: start tick timer, sample pot, update delay, go 1.
// RULE_04 - Mode 1, negative crossing: start tick timer for second half, go 0.
// RULE_05 - Mode 2, crossing: start 16-bit period timer, go 3.
// RULE_06 - Mode 3: average five positive intervals, classify 50 or 60 Hz, go 0.
// RULE_07 - Two back-to-back conversions per update; first result discarded.
// RULE_08 - Converter enabled only while the conversion sequence runs.
// RULE_09 - Result scaled to delay and clamped to a frequency-dependent maximum.
// RULE_10 - Conversion and delay update finish before the first tick after crossing.
// RULE_11 - Delay counts ticks since crossing; triac fires when count is reached.
// RULE_12 - Fixed offset added to delay for unequal detector high and low times.
// RULE_13 - After delay, burst of four gate pulses each half cycle.
// RULE_14 - Tick timer stops after delay and burst, until the next crossing.
// RULE_15 - Gate pins driven high as outputs straight out of reset.
// RULE_16 - Full initialisation after system reset and after watchdog reset.
// RULE_17 - Tick period 125 us, timer restarts on match; one tick sets pulse width.
// RULE_18 - Gate outputs active low; any reset returns them high.
// RULE_19 - Watchdog forces full reset if not serviced within 32 ms.
// RULE_20 - Zero result gives minimum delay, full scale gives maximum delay.
// RULE_21 - Zero-crossing input double synchronised; both edges give one-cycle events.
package tpf_pkg;

    // Clock and time base
    localparam int CLK_HZ          = 200_000_000;
    localparam int CYC_PER_US      = CLK_HZ / 1_000_000;
    localparam int TICK_US         = 125;
    localparam int TICK_CYCLES     = CYC_PER_US * TICK_US;
    localparam int WDT_MS          = 32;
    localparam int WDT_CYCLES      = CYC_PER_US * 1000 * WDT_MS;

    // Counter widths
    localparam int TICK_CNT_W      = 16;
    localparam int WDT_CNT_W       = 23;
    localparam int US_CNT_W        = 8;
    localparam int PERIOD_W        = 16;
    localparam int SUM_W           = 19;
    localparam int ADC_W           = 10;
    localparam int DELAY_W         = 7;
    localparam int TICKS_W         = 8;

    // Mains detection: period counted in microseconds, five intervals summed
    localparam logic [2:0]         MEAS_INTERVALS = 3'h5;
    localparam logic [PERIOD_W-1:0] MAINS_THRESH_US = 16'h479d;
    localparam logic [SUM_W-1:0]   MAINS_THRESH_SUM = 19'h16611;

    // Delay scaling: result shifted right by this many bits
    localparam int ADC_SHIFT       = 3;

    // Delay caps in ticks, leave room for the burst before the half-cycle end
    localparam logic [DELAY_W-1:0] DELAY_MAX_50 = 7'h44;
    localparam logic [DELAY_W-1:0] DELAY_MAX_60 = 7'h38;

    // Mark-space compensation offsets in ticks, per half cycle
    localparam logic [TICKS_W-1:0] POS_OFFSET   = 8'h02;
    localparam logic [TICKS_W-1:0] NEG_OFFSET   = 8'h01;

    // Burst: four low pulses separated by high gaps, one tick each
    localparam logic [3:0]         BURST_TICKS  = 4'h8;

    // Reset values
    localparam logic               GATE_IDLE    = 1'b1;
    localparam logic [DELAY_W-1:0] DELAY_RESET  = 7'h44;

    // Operating modes; declaration order gives codes 0 to 3
    typedef enum logic [1:0] {
        TPF_POS_HALF,
        TPF_NEG_HALF,
        TPF_SYNC,
        TPF_DETECT
    } tpf_mode_t;

    // Converter sequencer
    typedef enum logic [1:0] {
        TPF_ADC_IDLE,
        TPF_ADC_DUMMY,
        TPF_ADC_REAL
    } tpf_adc_t;

endpackage

// *** tpf_far_side_model.sv ***
`timescale 1ns/1ps
module tpf_far_side_model (
    // Clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    // Converter handshake
    input  wire logic                      adc_enable,
    input  wire logic                      adc_start,
    output logic                           adc_done,
    output logic [tpf_pkg::ADC_W-1:0]      pot_analog_input,
    // Bench controls: wiper level and conversion time
    input  wire logic [tpf_pkg::ADC_W-1:0] pot_level,
    input  wire logic [5:0]                latency
);
    logic [5:0] busy_cnt;
    logic       second;

    // Result bus is valid only with done; otherwise it toggles so stale data never looks right
    always_ff @(posedge clk_sys) begin
        adc_done         <= 1'b0;
        pot_analog_input <= ~pot_analog_input;
        if (rst || !adc_enable) begin
            busy_cnt <= 6'h00;
            second   <= 1'b0;
            if (rst) pot_analog_input <= 10'h2aa;
        end else if (adc_start) begin
            busy_cnt <= latency;
        end else if (busy_cnt == 6'h01) begin
            adc_done         <= 1'b1;
            second           <= 1'b1;
            // A freshly powered converter reads wrong the first time
            pot_analog_input <= second ? pot_level : ~pot_level;
            busy_cnt         <= 6'h00;
        end else if (busy_cnt != 6'h00) begin
            busy_cnt <= busy_cnt - 6'h01;
        end
    end
endmodule

// *** tpf_triac_ctrl_chk.sv ***
`timescale 1ns/1ps
module tpf_triac_ctrl_chk #(
    parameter int TICK_CYCLES = 20,
    parameter int WDT_CYCLES  = 5000
) (
    // Clock and reset
    input wire logic                      clk_sys,
    input wire logic                      rst,
    // Crossing and converter
    input wire logic                      zero_cross_in,
    input wire logic                      adc_enable,
    input wire logic                      adc_start,
    input wire logic                      adc_done,
    input wire logic [tpf_pkg::ADC_W-1:0] pot_analog_input,
    // Gates and status
    input wire logic                      gate_trigger_out_a_n,
    input wire logic                      gate_trigger_out_b_n,
    input wire logic                      gate_drive_oe,
    input wire logic [1:0]                mode,
    input wire logic                      mains_is_60hz,
    input wire logic                      wdt_reset
);
    int low_cnt;
    int en_cnt;
    int quiet_cnt;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Run lengths, so long spans need no long repetitions
    always_ff @(posedge clk_sys) begin
        low_cnt <= (rst || gate_trigger_out_a_n) ? 0 : low_cnt + 1;
        en_cnt  <= (rst || !adc_enable) ? 0 : en_cnt + 1;
    end

    // Cycles since the detector input last moved
    always_ff @(posedge clk_sys) begin
        quiet_cnt <= (rst || $changed(zero_cross_in)) ? 0 : quiet_cnt + 1;
    end

    a_reset_gates_idle: assert property (disable iff (1'b0) rst |=> gate_trigger_out_a_n && mode == 2'h2)
        else $error("gate or mode not idle after reset");
    a_oe_driving: assert property (gate_drive_oe)
        else $error("gate pins not driven");
    a_gates_paired: assert property (gate_trigger_out_a_n == gate_trigger_out_b_n)
        else $error("gate outputs differ");
    a_mode_order_legal: assert property ($changed(mode) |-> mode == 2'h2 ||
        ($past(mode) == 2'h2 && mode == 2'h3) || ($past(mode) == 2'h3 && mode == 2'h0) ||
        ($past(mode) == 2'h0 && mode == 2'h1) || ($past(mode) == 2'h1 && mode == 2'h0))
        else $error("illegal mode step");
    a_conv_on_pos: assert property ($rose(adc_enable) |-> adc_start && mode == 2'h1)
        else $error("converter started outside positive crossing");
    a_start_pulse: assert property (adc_start |-> adc_enable ##1 !adc_start)
        else $error("start not a single pulse while enabled");
    a_conv_before_tick: assert property (en_cnt <= TICK_CYCLES)
        else $error("converter on past the first tick");
    a_pulse_one_tick: assert property ($rose(gate_trigger_out_a_n) && !$past(wdt_reset) && !$past(rst)
        |-> low_cnt == TICK_CYCLES)
        else $error("gate pulse width wrong");
    a_wdt_not_early: assert property (wdt_reset |-> quiet_cnt >= WDT_CYCLES)
        else $error("watchdog fired early");
    a_wdt_restarts: assert property (wdt_reset |=> mode == 2'h2 && gate_trigger_out_a_n && !mains_is_60hz)
        else $error("watchdog did not reinitialise");
endmodule

// *** tpf_triac_ctrl_tb.sv ***
`timescale 1ns/1ps
module tpf_triac_ctrl_tb;
    localparam int TICK  = 20;
    localparam int WDT   = 5000;
    localparam int HALF  = 1600;
    localparam int LIMIT = 80000;
    localparam logic [9:0] CORNER [4] = '{10'h000, 10'h3ff, 10'h1c7, 10'h1c8};

    logic                      clk_sys, rst, zero_cross_in, adc_enable, adc_start, adc_done;
    logic [tpf_pkg::ADC_W-1:0] pot_analog_input, pot_level;
    logic                      gate_trigger_out_a_n, gate_trigger_out_b_n, gate_drive_oe;
    logic                      mains_is_60hz, wdt_reset;
    logic [1:0]                mode;
    logic [5:0]                latency;
    int                        num_errors, total_checks;
    int                        cyc = 0;

    tpf_triac_ctrl #(.TICK_CYCLES(TICK), .WDT_CYCLES(WDT)) uut (.clk_sys(clk_sys), .rst(rst),
        .zero_cross_in(zero_cross_in), .adc_enable(adc_enable), .adc_start(adc_start), .adc_done(adc_done),
        .pot_analog_input(pot_analog_input), .gate_trigger_out_a_n(gate_trigger_out_a_n),
        .gate_trigger_out_b_n(gate_trigger_out_b_n), .gate_drive_oe(gate_drive_oe), .mode(mode),
        .mains_is_60hz(mains_is_60hz), .wdt_reset(wdt_reset));

    tpf_far_side_model far_side (.clk_sys(clk_sys), .rst(rst), .adc_enable(adc_enable), .adc_start(adc_start),
        .adc_done(adc_done), .pot_analog_input(pot_analog_input), .pot_level(pot_level), .latency(latency));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Hang guard
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            num_errors = num_errors + 1;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Scaled wiper reading, capped for 60 Hz mains
    function automatic int delay_of(input logic [9:0] v);
        int d;
        d = int'(v >> tpf_pkg::ADC_SHIFT);
        return d > int'(tpf_pkg::DELAY_MAX_60) ? int'(tpf_pkg::DELAY_MAX_60) : d;
    endfunction

    task automatic idle_check();
        check("idle_state", {gate_trigger_out_a_n, gate_trigger_out_b_n, gate_drive_oe, mode, adc_enable,
            adc_start, mains_is_60hz}, 16'h00f0);
    endtask

    // One mains half cycle; fire below zero means no burst may appear
    task automatic half(input logic lvl, input int fire, input logic [1:0] exp_mode);
        int first, lows, falls, pair, mch;
        logic prev;
        logic [1:0] m0;
        first = -1;
        lows = 0;
        falls = 0;
        pair = 0;
        mch = -1;
        prev = 1'b1;
        m0 = mode;
        zero_cross_in <= lvl;
        for (int i = 0; i < HALF; i++) begin
            @(negedge clk_sys);
            if (gate_trigger_out_a_n !== gate_trigger_out_b_n) pair++;
            if (gate_trigger_out_a_n === 1'b0) lows++;
            if (prev === 1'b1 && gate_trigger_out_a_n === 1'b0) begin
                falls++;
                if (first < 0) first = i;
            end
            if (mch < 0 && mode !== m0) mch = i;
            prev = gate_trigger_out_a_n;
            @(posedge clk_sys);
        end
        check("gate_pair", pair, 0);
        check("fire_time", first, fire < 0 ? -1 : 4 + TICK * fire);
        check("low_cycles", lows, fire < 0 ? 0 : 4 * TICK);
        check("pulses", falls, fire < 0 ? 0 : 4);
        check("mode", mode, exp_mode);
        if (mch >= 0) check("mode_delay", mch, 3);
    endtask

    initial begin
        int d, k;
        logic [9:0] v;
        rst = 1'b1;
        zero_cross_in = 1'b0;
        pot_level = 10'h000;
        latency = 6'h03;
        num_errors = 0;
        total_checks = 0;
        void'($urandom(15));
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        @(negedge clk_sys);
        idle_check();
        @(posedge clk_sys);
        // Sync, then five measured intervals; short periods read as 60 Hz
        half(1'b1, -1, 2'h3);
        for (int i = 0; i < 5; i++) begin
            half(1'b0, -1, 2'h3);
            half(1'b1, -1, i == 4 ? 2'h0 : 2'h3);
        end
        check("mains_60", mains_is_60hz, 1'b1);
        half(1'b0, -1, 2'h0);
        // Corner wiper values first, then random ones
        for (int i = 0; i < 10; i++) begin
            v = i < 4 ? CORNER[i] : 10'($urandom);
            d = delay_of(v);
            pot_level <= v;
            half(1'b1, d + int'(tpf_pkg::POS_OFFSET), 2'h1);
            half(1'b0, d + int'(tpf_pkg::NEG_OFFSET), 2'h0);
        end
        // Slow converter misses the first tick: old delay must stay
        latency <= 6'h1e;
        pot_level <= 10'h100;
        half(1'b1, d + int'(tpf_pkg::POS_OFFSET), 2'h1);
        half(1'b0, d + int'(tpf_pkg::NEG_OFFSET), 2'h0);
        latency <= 6'h03;
        // Mains lost: watchdog must reinitialise
        k = 0;
        while (wdt_reset !== 1'b1 && k < 2 * WDT) begin
            @(negedge clk_sys);
            k++;
        end
        check("wdt_fired", wdt_reset, 1'b1);
        check("wdt_late", HALF + k >= WDT, 1'b1);
        @(negedge clk_sys);
        idle_check();
        @(posedge clk_sys);
        half(1'b1, -1, 2'h3);
        rst <= 1'b1;
        @(posedge clk_sys);
        rst <= 1'b0;
        @(negedge clk_sys);
        idle_check();
        repeat (4) @(negedge clk_sys);
        idle_check();
        report_and_stop();
    end
endmodule

bind tpf_triac_ctrl tpf_triac_ctrl_chk #(.TICK_CYCLES(TICK_CYCLES), .WDT_CYCLES(WDT_CYCLES)) u_chk (
    .clk_sys(clk_sys), .rst(rst), .zero_cross_in(zero_cross_in), .adc_enable(adc_enable), .adc_start(adc_start),
    .adc_done(adc_done), .pot_analog_input(pot_analog_input), .gate_trigger_out_a_n(gate_trigger_out_a_n),
    .gate_trigger_out_b_n(gate_trigger_out_b_n), .gate_drive_oe(gate_drive_oe), .mode(mode),
    .mains_is_60hz(mains_is_60hz), .wdt_reset(wdt_reset));
